// ---- design/acc_pkg.sv ----
// Constants for the comparator control block: register offsets, field
// positions and reset values. Assumes an APB master with 32-bit data.
// Operation
// (R1) Mux on, converter off: channel_select picks channel
// (R2) Otherwise negative input is the dedicated pin
// (R3) Mux enable is bit 6, read/write
// (R4) Result high when positive exceeds negative
// (R5) Result synchronized, one to two cycles late
// (R6) Bandgap select bit 6 chooses positive source
// (R7) Power-off bit 7 switches comparator off
// (R8) Mode: any, reserved, falling, rising edge
// (R9) Matching synchronized event sets flag bit 4
// (R10) Vector execution clears the flag
// (R11) Writing one clears flag, zero keeps
// (R12) Request while flag, enable bit 3, global
// (R13) Capture routing bit 2 feeds timer capture
// (R14) Software also sets timer capture interrupt enable
// (R15) Disable irq before changing mode bits
// (R16) Disable irq before changing power-off bit
// (R17) Buffer-off bits gate pin reads to zero
// (R18) Buffer register bits 7:2 read zero
// (R19) Channels usable only without converter power reduction
// (R20) Converter enable bit makes mux unavailable
// (R21) Reserved mode never sets the flag
// (R22) Writable bits reset to zero
package acc_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] ACC_OFS_MUXCTL = 12'h000;
	localparam logic [11:0] ACC_OFS_CSR = 12'h004;
	localparam logic [11:0] ACC_OFS_BUFDIS = 12'h008;
	localparam logic [11:0] ACC_OFS_CONV = 12'h00C;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ACC_B_MUXEN = 6;
	localparam int ACC_B_PWROFF = 7;
	localparam int ACC_B_BGSEL = 6;
	localparam int ACC_B_RESULT = 5;
	localparam int ACC_B_FLAG = 4;
	localparam int ACC_B_IRQEN = 3;
	localparam int ACC_B_CAPEN = 2;
	localparam int ACC_B_NEGOFF = 1;
	localparam int ACC_B_POSOFF = 0;
	// Converter shadow register: bit 7 enable, bit 6 power reduction, 2:0 channel
	localparam int ACC_B_CONVEN = 7;
	localparam int ACC_B_PRR = 6;
	// ----------------------------------------------------------------
	// Reset values and modes
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_RST_BYTE = 8'h00;
	localparam logic [1:0] ACC_MODE_ANY = 2'h0;
	localparam logic [1:0] ACC_MODE_FALL = 2'h2;
	localparam logic [1:0] ACC_MODE_RISE = 2'h3;
	localparam logic [1:0] ACC_SYNC_RST = 2'h0;
endpackage

// ---- design/acc_sync.sv ----
// Two-flop level synchronizer for one bit.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/10ps
module acc_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic d,
	output logic q
);
	import acc_pkg::*;
	// ----------------------------------------------------------------
	// Synchronizer stages
	// ----------------------------------------------------------------
	logic [1:0] stg_r; // First stage feeds only the second
	// Shift chain; first flop read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stg_r <= ACC_SYNC_RST;
		end else begin
			stg_r <= {stg_r[0], d};
		end
	end
	assign q = stg_r[1];
endmodule

// ---- design/acc_top.sv ----
// Comparator control logic: input selection, result synchronization,
// edge-selectable event flag, capture routing and pin buffer control.
// Assumes an APB master, an analog comparator outside, and a CPU that
// pulses vector_ack when it takes the comparator interrupt.
`timescale 1ns/10ps
module acc_top (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog comparator
	input wire logic comparator_raw,
	output logic neg_use_channel,
	output logic [2:0] neg_channel,
	output logic bandgap_positive_select,
	output logic comparator_power_off,
	// Pins
	input wire logic positive_pin_in,
	input wire logic negative_pin_in,
	output logic positive_pin_read,
	output logic negative_pin_read,
	output logic positive_pin_buffer_off,
	output logic negative_pin_buffer_off,
	// CPU and timer
	input wire logic global_irq_enable,
	input wire logic vector_ack,
	output logic comparator_irq,
	output logic capture_input
);
	import acc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic mux_en;        // Negative mux enable
		logic conv_en;       // Converter enable shadow
		logic conv_prr;      // Converter power reduction shadow
		logic [2:0] chan;    // Channel select
		logic pwr_off;       // Comparator power off
		logic bg_sel;        // Bandgap positive select
		logic flag;          // Event flag
		logic irq_en;        // Interrupt enable
		logic cap_en;        // Capture routing
		logic [1:0] mode;    // Interrupt mode
		logic neg_off;       // Negative pin buffer off
		logic pos_off;       // Positive pin buffer off
		logic res_d;         // Previous synchronized result
		logic [31:0] rdata;  // Read data
		logic ready;         // Access ready
		logic irq;           // Interrupt request
		logic cap;           // Capture front-end input
		logic pos_rd;        // Gated positive pin read
		logic neg_rd;        // Gated negative pin read
		logic use_ch; // Negative input taken from a channel
	} acc_state_s;

	acc_state_s st_r;
	acc_state_s st_nxt;

	// Synchronized inputs
	logic res_s; // Comparator result after two flops
	logic pos_s; // Positive pin level
	logic neg_s; // Negative pin level

	// ----------------------------------------------------------------
	// Synchronizers
	// ----------------------------------------------------------------
	// Result passes two flops, giving one to two cycles of latency
	acc_sync u_res (.pclk(pclk), .presetn(presetn), .d(comparator_raw), .q(res_s)); // [R5]
	acc_sync u_pos (.pclk(pclk), .presetn(presetn), .d(positive_pin_in), .q(pos_s));
	acc_sync u_neg (.pclk(pclk), .presetn(presetn), .d(negative_pin_in), .q(neg_s));

	// Bus and result-event strobes
	logic wr_en;
	logic rd_en;
	logic ev_rise;
	logic ev_fall;
	logic ev_hit;
	assign wr_en = psel && penable && pwrite && st_r.ready;
	assign rd_en = psel && !penable && !pwrite;
	assign ev_rise = res_s && !st_r.res_d;
	assign ev_fall = !res_s && st_r.res_d;

	// ----------------------------------------------------------------
	// Event decode
	// ----------------------------------------------------------------
	// Reserved code is excluded so it cannot set the flag
	always_comb begin
		unique case (st_r.mode)
			ACC_MODE_ANY: ev_hit = ev_rise || ev_fall; // [R8]
			ACC_MODE_FALL: ev_hit = ev_fall; // [R8]
			ACC_MODE_RISE: ev_hit = ev_rise; // [R8]
			default: ev_hit = 1'b0; // [R21]
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.res_d = res_s;
		// Zero-wait answer: ready in the access cycle
		st_nxt.ready = psel && !penable;
		// Writes update control on the completing edge
		if (wr_en) begin
			unique case (paddr)
				ACC_OFS_MUXCTL: begin
					st_nxt.mux_en = pwdata[ACC_B_MUXEN]; // [R3]
				end
				ACC_OFS_CSR: begin
					st_nxt.pwr_off = pwdata[ACC_B_PWROFF]; // [R7]
					st_nxt.bg_sel = pwdata[ACC_B_BGSEL];
					st_nxt.irq_en = pwdata[ACC_B_IRQEN];
					st_nxt.cap_en = pwdata[ACC_B_CAPEN];
					st_nxt.mode = pwdata[1:0];
					// Write one clears, zero keeps
					if (pwdata[ACC_B_FLAG]) begin
						st_nxt.flag = 1'b0; // [R11]
					end
				end
				ACC_OFS_BUFDIS: begin
					st_nxt.neg_off = pwdata[ACC_B_NEGOFF];
					st_nxt.pos_off = pwdata[ACC_B_POSOFF];
				end
				ACC_OFS_CONV: begin
					st_nxt.conv_en = pwdata[ACC_B_CONVEN];
					st_nxt.conv_prr = pwdata[ACC_B_PRR];
					st_nxt.chan = pwdata[2:0];
				end
				default: begin
				end
			endcase
		end
		// Vector execution clears the flag
		if (vector_ack) begin
			st_nxt.flag = 1'b0; // [R10]
		end
		// Hardware set wins over any clear in the same cycle
		if (ev_hit) begin
			st_nxt.flag = 1'b1; // [R9]
		end
		// Read data captured in setup so it stands in access
		if (rd_en) begin
			unique case (paddr)
				ACC_OFS_MUXCTL: st_nxt.rdata = {24'h000000, 1'b0, st_r.mux_en, 6'h00};
				ACC_OFS_CSR: st_nxt.rdata = {24'h000000, st_r.pwr_off, st_r.bg_sel,
					res_s, st_r.flag, st_r.irq_en, st_r.cap_en, st_r.mode}; // [R5]
				ACC_OFS_BUFDIS: st_nxt.rdata = {24'h000000, 6'h00,
					st_r.neg_off, st_r.pos_off}; // [R18]
				ACC_OFS_CONV: st_nxt.rdata = {24'h000000, st_r.conv_en, st_r.conv_prr,
					3'h0, st_r.chan};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
		// Request while flag, enable and global enable all hold
		st_nxt.irq = st_nxt.flag && st_nxt.irq_en && global_irq_enable; // [R12]
		// Capture gets the result only when routed
		st_nxt.cap = st_nxt.cap_en && res_s; // [R13]
		// Disabled buffers read as zero
		st_nxt.pos_rd = pos_s && !st_nxt.pos_off; // [R17]
		st_nxt.neg_rd = neg_s && !st_nxt.neg_off; // [R17]
		// Channel path only with mux on, converter off and unreduced power
		st_nxt.use_ch = st_nxt.mux_en && !st_nxt.conv_en; // [R1] [R2] [R20]
		st_nxt.use_ch = st_nxt.use_ch && !st_nxt.conv_prr; // [R19]
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Everything clears, selecting pins, any-change mode, irq off, powered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0; // [R22]
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output but the tied-low pslverr is a flop so no decode glitch reaches the analog mux;
	// result polarity (positive above negative) is the analog cell's.
	assign neg_use_channel = st_r.use_ch; // [R1] [R2]
	assign neg_channel = st_r.chan; // [R1]
	assign bandgap_positive_select = st_r.bg_sel; // [R6]
	assign comparator_power_off = st_r.pwr_off; // [R7]
	assign positive_pin_buffer_off = st_r.pos_off; // [R17]
	assign negative_pin_buffer_off = st_r.neg_off; // [R17]
	assign positive_pin_read = st_r.pos_rd;
	assign negative_pin_read = st_r.neg_rd;
	assign comparator_irq = st_r.irq;
	assign capture_input = st_r.cap;
	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = 1'b0;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Flag set and clear
	a_flag_rise: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		(st_r.mode == ACC_MODE_RISE && ev_rise) |=> st_r.flag)
		else $error("flag missed rising event");
	// Falling mode catches a falling result
	a_flag_fall: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		(st_r.mode == ACC_MODE_FALL && ev_fall) |=> st_r.flag)
		else $error("flag missed falling event");
	// Any-change mode catches either edge
	a_flag_toggle: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(st_r.mode == ACC_MODE_ANY && (ev_rise || ev_fall)) |=> st_r.flag)
		else $error("flag missed toggle event");
	a_reserved_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
		(st_r.mode == 2'h1 && !st_r.flag && !wr_en) |=> !st_r.flag)
		else $error("reserved mode set flag");
	a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		(wr_en && paddr == ACC_OFS_CSR && pwdata[ACC_B_FLAG] && !ev_hit) |=> !st_r.flag)
		else $error("write one did not clear flag");
	// Writing zero to the flag keeps it
	a_flag_keep: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		(wr_en && paddr == ACC_OFS_CSR && !pwdata[ACC_B_FLAG] && !vector_ack && st_r.flag)
		|=> st_r.flag)
		else $error("write zero cleared flag");
	a_vector_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		(vector_ack && !ev_hit) |=> !st_r.flag)
		else $error("vector did not clear flag");
	// Interrupt request and capture routing
	a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		comparator_irq |-> $past(st_nxt.irq_en))
		else $error("irq without enable");
	// Flag, enable and global enable together must raise the request
	a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(st_nxt.flag && st_nxt.irq_en && global_irq_enable) |=> comparator_irq)
		else $error("irq not raised");
	// The global enable alone holds the request off
	a_irq_global: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		!global_irq_enable |=> !comparator_irq)
		else $error("irq without global enable");
	// Capture input stays low unless routing is on
	a_cap_route: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		capture_input |-> st_r.cap_en)
		else $error("capture without routing");
	// Routed result reaches the capture front end one edge later
	a_cap_follow: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		(st_nxt.cap_en && res_s) |=> capture_input)
		else $error("routed result lost");
	// Input selection and reads
	a_neg_select: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		neg_use_channel |-> (st_r.mux_en && !st_r.conv_en))
		else $error("channel used while pin required");
	// Channel path must follow the channel code when allowed
	a_chan_select: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(st_r.mux_en && !st_r.conv_en && !st_r.conv_prr)
		|-> (neg_use_channel && neg_channel == st_r.chan))
		else $error("channel not selected");
	// Converter enable locks out the channels
	a_conv_block: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
		st_r.conv_en |-> !neg_use_channel)
		else $error("channel used while converter on");
	// Converter power reduction locks out the channels too
	a_prr_block: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
		st_r.conv_prr |-> !neg_use_channel)
		else $error("channel used while power reduced");
	a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		$rose(comparator_raw) ##0 comparator_raw[*3] |-> ##2 res_s)
		else $error("result not through sync");
	// Status read returns the synchronized result
	a_result_read: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(rd_en && paddr == ACC_OFS_CSR) |=> prdata[ACC_B_RESULT] == $past(res_s))
		else $error("result bit not synchronized value");
	a_buf_read: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		positive_pin_buffer_off |-> !positive_pin_read)
		else $error("disabled buffer read nonzero");
	// Negative buffer off gates its pin read too
	a_neg_buf_read: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		negative_pin_buffer_off |-> !negative_pin_read)
		else $error("disabled negative buffer read nonzero");
	// Unused buffer register bits read as zero
	a_buf_upper: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
		(rd_en && paddr == ACC_OFS_BUFDIS) |=> prdata[31:2] == 30'h00000000)
		else $error("unused buffer bits nonzero");
	a_mux_write: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(wr_en && paddr == ACC_OFS_MUXCTL) |=> st_r.mux_en == $past(pwdata[ACC_B_MUXEN]))
		else $error("mux enable not written");
	// Power-off bit follows a status-word write
	a_power_write: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(wr_en && paddr == ACC_OFS_CSR) |=> comparator_power_off == $past(pwdata[ACC_B_PWROFF]))
		else $error("power off not written");
	// Bandgap select follows a status-word write
	a_bg_write: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(wr_en && paddr == ACC_OFS_CSR)
		|=> bandgap_positive_select == $past(pwdata[ACC_B_BGSEL]))
		else $error("bandgap select not written");
endmodule

// ---- tb/acc_analog_model.sv ----
// Behavioural analog comparator with its input muxes, and the timer's
// capture interrupt gate.
// Assumes the bench drives all voltages in millivolts.
`timescale 1ns/10ps
module acc_analog_model (
	// Voltages
	input wire logic [11:0] pos_mv,
	input wire logic [11:0] neg_mv,
	input wire logic [11:0] bg_mv,
	input wire logic [95:0] chan_mv,
	// Controls from the block
	input wire logic neg_use_channel,
	input wire logic [2:0] neg_channel,
	input wire logic bandgap_positive_select,
	input wire logic comparator_power_off,
	// Timer capture front end
	input wire logic capture_input,
	input wire logic timer_capture_irq_enable,
	// Results
	output logic comparator_raw,
	output logic timer_capture_irq
);
	logic [11:0] p_v; // Selected positive level
	logic [11:0] n_v; // Selected negative level
	// ------------------------------------------------------------
	// Selection and compare
	// ------------------------------------------------------------
	// An unpowered comparator is held low, so no events come from it
	always_comb begin
		p_v = bandgap_positive_select ? bg_mv : pos_mv;
		n_v = neg_use_channel ? chan_mv[neg_channel*12 +: 12] : neg_mv;
		comparator_raw = !comparator_power_off && (p_v > n_v);
		// Capture interrupt only with the timer's own enable set
		timer_capture_irq = timer_capture_irq_enable && capture_input;
	end
endmodule

// ---- tb/test_comparator_control_logic.sv ----
// Self-checking bench for the comparator control block.
// Assumes zero-wait APB slave and the analog model on the far side.
`timescale 1ns/10ps
module test_comparator_control_logic;
	import acc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, comparator_raw, neg_use_channel, bandgap_positive_select;
	logic comparator_power_off, positive_pin_read, negative_pin_read, capture_input;
	logic positive_pin_buffer_off, negative_pin_buffer_off, comparator_irq;
	logic [2:0] neg_channel;
	logic positive_pin_in = 0, negative_pin_in = 0, global_irq_enable = 0, vector_ack = 0;
	logic timer_capture_irq_enable = 0, timer_capture_irq;
	logic [11:0] pos_mv = 12'h064, neg_mv = 12'h1F4, bg_mv = 12'h3E8;
	logic [95:0] chan_mv = 96'h0;
	logic [31:0] m;
	int num_errors = 0, compares = 0, seed = 99, c, k;
	// ------------------------------------------------------------
	// Design, far side and clock
	// ------------------------------------------------------------
	acc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .comparator_raw(comparator_raw), .neg_use_channel(neg_use_channel),
		.neg_channel(neg_channel), .bandgap_positive_select(bandgap_positive_select),
		.comparator_power_off(comparator_power_off), .positive_pin_in(positive_pin_in),
		.negative_pin_in(negative_pin_in), .positive_pin_read(positive_pin_read),
		.negative_pin_read(negative_pin_read), .positive_pin_buffer_off(positive_pin_buffer_off),
		.negative_pin_buffer_off(negative_pin_buffer_off), .global_irq_enable(global_irq_enable),
		.vector_ack(vector_ack), .comparator_irq(comparator_irq), .capture_input(capture_input));
	acc_analog_model u_ana (.pos_mv(pos_mv), .neg_mv(neg_mv), .bg_mv(bg_mv), .chan_mv(chan_mv),
		.neg_use_channel(neg_use_channel), .neg_channel(neg_channel),
		.bandgap_positive_select(bandgap_positive_select),
		.comparator_power_off(comparator_power_off), .comparator_raw(comparator_raw),
		.capture_input(capture_input), .timer_capture_irq_enable(timer_capture_irq_enable),
		.timer_capture_irq(timer_capture_irq));
	// 10 MHz clock
	initial begin
		forever #50 pclk = ~pclk;
	end
	// ------------------------------------------------------------
	// Tasks and expectations
	// ------------------------------------------------------------
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: word %h, want %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: bit %b, want %b", $time, got, exp);
		end
	endtask
	// Channel path only with mux on, converter off and powered
	function automatic logic exp_use(input logic me, input logic ce, input logic pr);
		return me && !ce && !pr;
	endfunction
	// Flag set by any change, or by the chosen edge; reserved never
	function automatic logic exp_flag(input logic [1:0] md, input logic rise);
		return md == ACC_MODE_ANY || md == (rise ? ACC_MODE_RISE : ACC_MODE_FALL);
	endfunction
	task automatic print_verdict();
		$display("errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, last one an unmapped word
		for (c = 0; c < 5; c++) begin
			apb(1'b0, 12'(c * 4), 32'h0);
			chk_reg(rd, 32'h0);
		end
		chk_bit(pslverr, 1'b0);
		apb(1'b1, ACC_OFS_MUXCTL, 32'hFFFFFFFF);
		apb(1'b0, ACC_OFS_MUXCTL, 32'h0);
		chk_reg(rd, 32'h40);
		// Buffers off gate the pin reads
		positive_pin_in <= 1'b1;
		negative_pin_in <= 1'b1;
		apb(1'b1, ACC_OFS_BUFDIS, 32'hFFFFFFFF);
		apb(1'b0, ACC_OFS_BUFDIS, 32'h0);
		chk_reg(rd, 32'h3);
		chk_bit(positive_pin_read | negative_pin_read, 1'b0);
		chk_bit(positive_pin_buffer_off & negative_pin_buffer_off, 1'b1);
		apb(1'b1, ACC_OFS_BUFDIS, 32'h1);
		repeat (3) @(posedge pclk);
		chk_bit(negative_pin_read, 1'b1);
		chk_bit(positive_pin_read, 1'b0);
		// Negative source: every channel code, then random settings
		for (c = 0; c < 8; c++) begin
			chan_mv[c*12 +: 12] <= 12'($random(seed)) & 12'h0FF;
		end
		for (c = 0; c < 16; c++) begin
			m = (c < 8) ? (32'h100 | c) : $random(seed);
			apb(1'b1, ACC_OFS_MUXCTL, {25'h0, m[8], 6'h0});
			apb(1'b1, ACC_OFS_CONV, m & 32'hC7);
			repeat (4) @(posedge pclk);
			chk_bit(neg_use_channel, exp_use(m[8], m[7], m[6]));
			if (exp_use(m[8], m[7], m[6]))
				chk_reg({29'h0, neg_channel}, {29'h0, m[2:0]});
			apb(1'b0, ACC_OFS_CSR, 32'h0);
			chk_bit(rd[5], exp_use(m[8], m[7], m[6]) ? pos_mv > chan_mv[m[2:0]*12 +: 12]
				: pos_mv > neg_mv);
		end
		// Bandgap and power-off; an unpowered result reads low
		apb(1'b1, ACC_OFS_MUXCTL, 32'h0);
		apb(1'b1, ACC_OFS_CSR, 32'hC0);
		repeat (4) @(posedge pclk);
		// Source switches raised the flag in any-change mode; clear it first
		apb(1'b1, ACC_OFS_CSR, 32'hD0);
		apb(1'b0, ACC_OFS_CSR, 32'h0);
		chk_reg(rd, 32'hC0);
		chk_bit(bandgap_positive_select & comparator_power_off, 1'b1);
		apb(1'b1, ACC_OFS_CSR, 32'h40);
		repeat (4) @(posedge pclk);
		apb(1'b1, ACC_OFS_CSR, 32'h50);
		apb(1'b0, ACC_OFS_CSR, 32'h0);
		chk_reg(rd, 32'h60);
		apb(1'b1, ACC_OFS_CSR, 32'h0);
		// Each mode against a rising then a falling result
		for (k = 0; k < 4; k++) begin
			for (c = 0; c < 2; c++) begin
				apb(1'b1, ACC_OFS_CSR, 32'h10 | k);
				pos_mv <= (c == 0) ? 12'h384 : 12'h064;
				repeat (5) @(posedge pclk);
				apb(1'b0, ACC_OFS_CSR, 32'h0);
				chk_bit(rd[4], exp_flag(2'(k), c == 0));
			end
		end
		// Request, global gate, vector clear; writing zero keeps the flag
		apb(1'b1, ACC_OFS_CSR, 32'h13);
		pos_mv <= 12'h384;
		repeat (5) @(posedge pclk);
		apb(1'b1, ACC_OFS_CSR, 32'h0B);
		global_irq_enable <= 1'b1;
		repeat (2) @(posedge pclk);
		chk_bit(comparator_irq, 1'b1);
		global_irq_enable <= 1'b0;
		repeat (2) @(posedge pclk);
		chk_bit(comparator_irq, 1'b0);
		vector_ack <= 1'b1;
		@(posedge pclk);
		vector_ack <= 1'b0;
		global_irq_enable <= 1'b1;
		repeat (2) @(posedge pclk);
		chk_bit(comparator_irq, 1'b0);
		apb(1'b0, ACC_OFS_CSR, 32'h0);
		chk_reg(rd, 32'h2B);
		// Capture routing follows the result only when enabled
		timer_capture_irq_enable <= 1'b1;
		apb(1'b1, ACC_OFS_CSR, 32'h03);
		apb(1'b1, ACC_OFS_CSR, 32'h07);
		repeat (4) @(posedge pclk);
		chk_bit(capture_input, 1'b1);
		chk_bit(timer_capture_irq, 1'b1);
		pos_mv <= 12'h064;
		repeat (5) @(posedge pclk);
		chk_bit(capture_input, 1'b0);
		pos_mv <= 12'h384;
		apb(1'b1, ACC_OFS_CSR, 32'h03);
		repeat (5) @(posedge pclk);
		chk_bit(capture_input, 1'b0);
		print_verdict();
	end
endmodule
